// ==== design/sopc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module sopc_top (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    // own device id
    input  wire logic [7:0] device_id,
    // select pin, open drain
    output var  logic       external_select_output_out,
    output var  logic       external_select_output_oe
);
    import sopc_pkg::*;

    typedef struct packed {
        sopc_phase_t phase;
        logic [3:0]  bitn;
        logic [7:0]  shift;
        logic        oe_cmd;
        logic        ack_drive;
        logic        pending;
        logic        armed_stop;
        logic        sel;
        logic        scl_d;
        logic        sda_d;
        logic        clk_seen;
    } sopc_state_t;

    sopc_state_t s_reg;
    sopc_state_t s_next;
    logic        scl_s;
    logic        sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;

    sopc_sync u_scl (.core_clk(core_clk), .rst_n(rst_n), .async_in(scl_in), .sync_out(scl_s));
    sopc_sync u_sda (.core_clk(core_clk), .rst_n(rst_n), .async_in(sda_in), .sync_out(sda_s));

    assign scl_rise = scl_s && !s_reg.scl_d;
    assign scl_fall = !scl_s && s_reg.scl_d;
    assign start_c  = scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s;
    assign stop_c   = scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s;

    always_comb begin
        s_next       = s_reg;
        s_next.scl_d = scl_s;
        s_next.sda_d = sda_s;
        if (start_c) begin
            s_next.phase      = SOPC_CTRL;
            s_next.bitn       = BIT_NONE;
            s_next.ack_drive  = 1'b0;
            s_next.pending    = 1'b0;
            s_next.armed_stop = 1'b0;
            s_next.clk_seen   = 1'b0;
        end else if (stop_c) begin
            s_next.phase     = SOPC_IDLE;
            s_next.ack_drive = 1'b0;
            s_next.pending   = 1'b0;
        end else if (scl_rise) begin
            // the clock fall that closes a start is not a bit; count only after a rise
            s_next.clk_seen = 1'b1;
            // pin follows the latched bit on the rise before stop
            if (s_reg.armed_stop && s_reg.phase == SOPC_BODY) begin
                s_next.sel        = s_reg.oe_cmd;
                s_next.armed_stop = 1'b0;
            end
            // update on the rise after the id acknowledge
            if (s_reg.pending) begin
                s_next.sel     = s_reg.oe_cmd;
                s_next.pending = 1'b0;
            end
            if (s_reg.bitn <= BIT_LAST && s_reg.phase != SOPC_IDLE) begin
                s_next.shift = {s_reg.shift[6:0], sda_s};
            end
        end else if (scl_fall && s_reg.phase != SOPC_IDLE && s_reg.clk_seen) begin
            s_next.ack_drive = 1'b0;
            if (s_reg.bitn == BIT_LAST) begin
                s_next.bitn = BIT_ACK;
                unique case (s_reg.phase)
                    SOPC_CTRL: begin
                        // acknowledge our control code on the ninth pulse
                        if (s_reg.shift[7:4] == CTRL_CODE) begin
                            s_next.ack_drive = 1'b1;
                            // enable bit sampled fresh for this command
                            s_next.oe_cmd    = s_reg.shift[OE_BIT];
                        end else begin
                            s_next.phase = SOPC_IDLE;
                        end
                    end
                    SOPC_ID: begin
                        // mismatch: no ack, no pin update
                        if (s_reg.shift == device_id) begin
                            s_next.ack_drive = 1'b1;
                        end else begin
                            s_next.phase = SOPC_IGNORE;
                        end
                    end
                    SOPC_BODY: begin
                        s_next.ack_drive = 1'b1;
                    end
                    SOPC_IGNORE: begin
                        s_next.ack_drive = 1'b0;
                    end
                    default: begin
                        s_next.phase = SOPC_IDLE;
                    end
                endcase
            end else if (s_reg.bitn == BIT_ACK) begin
                s_next.bitn = BIT_NONE;
                if (s_reg.phase == SOPC_CTRL) begin
                    s_next.phase = SOPC_ID;
                end else if (s_reg.phase == SOPC_ID) begin
                    s_next.phase      = SOPC_BODY;
                    // enable set: pull low on next rise
                    s_next.pending    = s_reg.oe_cmd;
                    // otherwise latch bit just before stop
                    s_next.armed_stop = !s_reg.oe_cmd;
                end
            end else begin
                s_next.bitn = s_reg.bitn + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg            <= '0;
            s_reg.phase      <= SOPC_IDLE;
            s_reg.sel        <= 1'b0;
            s_reg.scl_d      <= 1'b1;
            s_reg.sda_d      <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // open drain: output value is always low
    assign external_select_output_out = 1'b0;
    assign external_select_output_oe  = s_reg.sel;
    assign sda_out                    = 1'b0;
    assign sda_oe                     = s_reg.ack_drive;

    AST_RESET_RELEASED: assert property (@(posedge core_clk)
        $rose(rst_n) |-> !external_select_output_oe)
        else $error("select output driven after reset");

    AST_NEVER_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        external_select_output_out == 1'b0)
        else $error("select output driven high");

    AST_LATCHED: assert property (@(posedge core_clk) disable iff (!rst_n)
        !scl_rise |=> $stable(external_select_output_oe))
        else $error("select changed without clock rise");

    AST_PULL_AFTER_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scl_rise && s_reg.pending && !start_c && !stop_c) |=>
        external_select_output_oe)
        else $error("select not pulled after id acknowledge");

    AST_BEFORE_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scl_rise && s_reg.armed_stop && s_reg.phase == SOPC_BODY && !start_c && !stop_c)
        |=> external_select_output_oe == $past(s_reg.oe_cmd))
        else $error("select not updated before stop");

    AST_MISMATCH_NOACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_reg.phase == SOPC_IGNORE) |-> !sda_oe)
        else $error("acknowledge on mismatched id");

    AST_MISMATCH_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_reg.phase == SOPC_IGNORE) |=> $stable(external_select_output_oe))
        else $error("select changed on mismatched id");

    AST_CTRL_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scl_fall && s_reg.phase == SOPC_CTRL && s_reg.bitn == BIT_LAST && !start_c
        && s_reg.shift[7:4] == CTRL_CODE) |=> sda_oe)
        else $error("control byte not acknowledged");

    AST_OE_SAMPLED: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scl_fall && s_reg.phase == SOPC_CTRL && s_reg.bitn == BIT_LAST && !start_c
        && s_reg.shift[7:4] == CTRL_CODE) |=> s_reg.oe_cmd == $past(s_reg.shift[OE_BIT]))
        else $error("enable bit not captured");

    AST_EN_PULLS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scl_rise && (s_reg.pending || s_reg.armed_stop) && s_reg.phase == SOPC_BODY)
        |=> external_select_output_oe == $past(s_reg.oe_cmd))
        else $error("select does not follow enable bit");

    // ack only in the ack slot
    AST_ACK_SLOT: assert property (@(posedge core_clk) disable iff (!rst_n)
        sda_oe |-> s_reg.bitn == BIT_ACK)
        else $error("acknowledge outside the ack slot");

    // no ack for a foreign control code
    AST_IDLE_NOACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_reg.phase == SOPC_IDLE) |-> !sda_oe)
        else $error("acknowledge while idle");

    COV_PULL: cover property (@(posedge core_clk) $rose(external_select_output_oe));
    COV_RELEASE: cover property (@(posedge core_clk) $fell(external_select_output_oe));
    COV_IGNORE: cover property (@(posedge core_clk) s_reg.phase == SOPC_IGNORE);
    COV_ACK: cover property (@(posedge core_clk) $rose(sda_oe));
endmodule : sopc_top
`default_nettype wire

// ==== design/sopc_pkg.sv ====
package sopc_pkg;
    // control code nibble in the control byte (bits 7:4)
    localparam logic [3:0] CTRL_CODE     = 4'h6;
    // position of the output enable bit in the control byte
    localparam int         OE_BIT        = 3;
    localparam int         RW_BIT        = 0;
    localparam logic [7:0] ID_DEFAULT    = 8'h00;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [3:0] BIT_NONE      = 4'h0;
    localparam logic [1:0] SYNC_RESET    = 2'h3;

    typedef enum {
        SOPC_IDLE,
        SOPC_CTRL,
        SOPC_ID,
        SOPC_BODY,
        SOPC_IGNORE
    } sopc_phase_t;
endpackage : sopc_pkg

// ==== design/sopc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser for one pin level
module sopc_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic async_in,
    output var  logic sync_out
);
    import sopc_pkg::*;

    logic [1:0] stage_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= SYNC_RESET;
        end else begin
            stage_reg <= {stage_reg[0], async_in};
        end
    end

    assign sync_out = stage_reg[1];
endmodule : sopc_sync
`default_nettype wire

// ==== verif/sopc_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// bus master model: drives the bus clock and pulls the data wire low
module sopc_master (
    // clock
    input  wire logic core_clk,
    // bus wires
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : w
    task automatic start();
        sda_low = 1'h1;
        w(8);
        scl = 1'h0;
    endtask : start
    // bus clock stands high between frames; one bit is 160 ns
    task automatic send_bit(input logic b, output logic seen);
        w(4);
        sda_low = ~b;
        w(4);
        scl = 1'h1;
        w(4);
        seen = sda;
        w(4);
        scl = 1'h0;
    endtask : send_bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], s);
        end
        send_bit(1'h1, s);
        ack = ~s;
    endtask : send_byte
    // stop may follow the id byte
    task automatic stop();
        w(4);
        sda_low = 1'h1;
        w(4);
        scl = 1'h1;
        w(8);
        sda_low = 1'h0;
        w(8);
    endtask : stop
endmodule : sopc_master
`default_nettype wire

// ==== verif/select_output_pin_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module select_output_pin_control_tb;
    import sopc_pkg::*;
    localparam logic [7:0] OWN_ID = 8'hA5;
    logic core_clk = 1'h0;
    logic rst_n    = 1'h0;
    logic scl, m_low, sda_out, sda_oe, sel_out, sel_oe, sda, ac, ai, s;
    int   fail_count = 0;
    int   num_checks = 0;
    always #5 core_clk = ~core_clk;
    // open-drain data wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'h1) & ~m_low;
    sopc_top DUT (
        .core_clk                   (core_clk),
        .rst_n                      (rst_n),
        .scl_in                     (scl),
        .sda_in                     (sda),
        .sda_out                    (sda_out),
        .sda_oe                     (sda_oe),
        .device_id                  (OWN_ID),
        .external_select_output_out (sel_out),
        .external_select_output_oe  (sel_oe)
    );
    sopc_master M (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask : check
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic cmd(input logic en, input logic [7:0] id);
        M.start();
        M.send_byte({CTRL_CODE, en, 3'h0}, ac);
        M.send_byte(id, ai);
    endtask : cmd
    task automatic t_reset();
        check(sel_oe, 1'h0);
        check(sda_oe, 1'h0);
    endtask : t_reset
    task automatic t_full_assert();
        cmd(1'h1, OWN_ID);
        check(ac, 1'h1);
        check(ai, 1'h1);
        check(sel_oe, 1'h0);
        M.send_bit(1'h0, s);
        check(sel_oe, 1'h1);
        check(sel_out, 1'h0);
        M.stop();
        M.w(40);
        check(sel_oe, 1'h1);
    endtask : t_full_assert
    task automatic t_mismatch();
        cmd(1'h0, OWN_ID ^ 8'h5A);
        check(ac, 1'h1);
        check(ai, 1'h0);
        M.stop();
        check(sel_oe, 1'h1);
    endtask : t_mismatch
    // foreign control code: no acknowledge, pin kept
    task automatic t_wrong_code();
        M.start();
        M.send_byte({~CTRL_CODE, 1'h0, 3'h0}, ac);
        check(ac, 1'h0);
        M.stop();
        check(sel_oe, 1'h1);
    endtask : t_wrong_code
    // reset in mid-run releases the pin again
    task automatic t_rereset();
        rst_n = 1'h0;
        M.w(3);
        check(sel_oe, 1'h0);
        rst_n = 1'h1;
        M.w(5);
        check(sel_oe, 1'h0);
    endtask : t_rereset
    // partial command: pin changes at the clock rise before stop
    task automatic t_partial(input logic en);
        cmd(en, OWN_ID);
        check(ai, 1'h1);
        check(sel_oe, ~en);
        fork
            M.stop();
            begin
                M.w(13);
                check(sel_oe, en);
            end
        join
        check(sel_oe, en);
    endtask : t_partial
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        t_reset();
        rst_n = 1'h1;
        M.w(5);
        t_full_assert();
        t_mismatch();
        t_wrong_code();
        t_partial(1'h0);
        t_partial(1'h1);
        t_rereset();
        finish_test();
    end
endmodule : select_output_pin_control_tb
`default_nettype wire
